// File: design/afpg_pkg.sv
package afpg_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_SIZE = 8'h00;
   localparam logic [7:0] ADDR_GRID = 8'h04;
   localparam logic [7:0] ADDR_ORIGIN = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0c;
   localparam logic [7:0] ADDR_FILT = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   // field positions
   localparam int WIDTH_LSB = 16;
   localparam int HEIGHT_LSB = 0;
   localparam int STEP_LSB = 13;
   localparam int ROWS_LSB = 6;
   localparam int COLS_LSB = 0;
   localparam int HORG_LSB = 16;
   localparam int VORG_LSB = 0;
   localparam int EN_BIT = 0;
   localparam int MED_BIT = 2;
   localparam int FILT_LSB = 0;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_COL_LSB = 8;
   localparam int ST_ROW_LSB = 16;
   // reset values
   localparam logic [6:0] RST_WIDTH = 7'h00;
   localparam logic [6:0] RST_HEIGHT = 7'h00;
   localparam logic [3:0] RST_STEP = 4'h0;
   localparam logic [6:0] RST_ROWS = 7'h00;
   localparam logic [5:0] RST_COLS = 6'h00;
   localparam logic [11:0] RST_ORG = 12'h000;
   localparam logic [11:0] RST_FILT = 12'h000;

   typedef enum logic [1:0] {
      AFPG_IDLE = 2'b00,
      AFPG_WAIT = 2'b01,
      AFPG_ROWS = 2'b11,
      AFPG_DONE = 2'b10
   } afpg_state_t;

   typedef struct packed {
      logic valid;
      logic sof;
      logic sol;
   } afpg_pix_t;

   typedef struct packed {
      logic in_paxel;
      logic first;
      logic [5:0] col;
      logic [6:0] row;
      logic filter_clear;
   } afpg_grid_t;
endpackage

// File: design/afpg_grid.sv
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
// Operation
// - paxel width is 2*(width field+1) pixels
// - paxel height is 2*(height field+1) lines
// - line step inside paxel is 2*(field+1)
// - step field zero processes every line
// - skips 0 to 30 lines between pairs
// - first two lines of paxel always processed
// - row count field is rows minus one
// - column count field is columns minus one
// - first row begins at grid v origin line
// - filter origin match clears filter next pixel
// - paxels processed only while engine enabled
module afpg_grid
   import afpg_pkg::*;
#(
   parameter int POS_W = 12
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire afpg_pix_t pix,
   output afpg_grid_t grid
);

   logic [6:0] width_f;
   logic [6:0] height_f;
   logic [3:0] step_f;
   logic [6:0] rows_f;
   logic [5:0] cols_f;
   logic [11:0] h_org;
   logic [11:0] v_org;
   logic [11:0] filt_org;
   logic engine_en;
   logic median_en;

   afpg_state_t vstate;
   logic [POS_W-1:0] hcnt;
   logic [POS_W-1:0] vcnt;
   logic [7:0] ln;
   logic [4:0] poff;
   logic [6:0] row;
   logic h_on;
   logic h_done;
   logic [5:0] col;
   logic [7:0] cpix;
   logic frame_done;

   afpg_state_t next_vstate;
   logic [POS_W-1:0] next_h;
   logic [POS_W-1:0] next_v;
   logic [7:0] next_ln;
   logic [4:0] next_poff;
   logic [6:0] next_row;
   logic next_h_on;
   logic next_h_done;
   logic [5:0] next_col;
   logic [7:0] next_cpix;

   logic [7:0] wlast;
   logic [7:0] hlast;
   logic [4:0] slast;
   logic go;
   logic wr_size;
   logic wr_grid;
   logic wr_org;
   logic wr_ctrl;
   logic wr_filt;

   assign wlast = {width_f, 1'b1};
   assign hlast = {height_f, 1'b1};
   assign slast = {step_f, 1'b1};
   assign go = ce && pix.valid;
   assign wr_size = ce && reg_wr && reg_addr == ADDR_SIZE;
   assign wr_grid = ce && reg_wr && reg_addr == ADDR_GRID;
   assign wr_org = ce && reg_wr && reg_addr == ADDR_ORIGIN;
   assign wr_ctrl = ce && reg_wr && reg_addr == ADDR_CTRL;
   assign wr_filt = ce && reg_wr && reg_addr == ADDR_FILT;

   // only the defined fields are stored, so reserved bits stay zero
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         width_f <= RST_WIDTH;
         height_f <= RST_HEIGHT;
      end else if (wr_size) begin
         width_f <= reg_wdata[WIDTH_LSB +: 7];
         height_f <= reg_wdata[HEIGHT_LSB +: 7];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         step_f <= RST_STEP;
         rows_f <= RST_ROWS;
         cols_f <= RST_COLS;
      end else if (wr_grid) begin
         step_f <= reg_wdata[STEP_LSB +: 4];
         rows_f <= reg_wdata[ROWS_LSB +: 7];
         cols_f <= reg_wdata[COLS_LSB +: 6];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         h_org <= RST_ORG;
         v_org <= RST_ORG;
      end else if (wr_org) begin
         h_org <= reg_wdata[HORG_LSB +: 12];
         v_org <= reg_wdata[VORG_LSB +: 12];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         engine_en <= 1'b0;
         median_en <= 1'b0;
         filt_org <= RST_FILT;
      end else begin
         if (wr_ctrl) begin
            engine_en <= reg_wdata[EN_BIT];
            median_en <= reg_wdata[MED_BIT];
         end
         if (wr_filt) begin
            filt_org <= reg_wdata[FILT_LSB +: 12];
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (ce) begin
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            if (reg_addr == ADDR_SIZE) begin
               reg_rdata[WIDTH_LSB +: 7] <= width_f;
               reg_rdata[HEIGHT_LSB +: 7] <= height_f;
            end else if (reg_addr == ADDR_GRID) begin
               reg_rdata[STEP_LSB +: 4] <= step_f;
               reg_rdata[ROWS_LSB +: 7] <= rows_f;
               reg_rdata[COLS_LSB +: 6] <= cols_f;
            end else if (reg_addr == ADDR_ORIGIN) begin
               reg_rdata[HORG_LSB +: 12] <= h_org;
               reg_rdata[VORG_LSB +: 12] <= v_org;
            end else if (reg_addr == ADDR_CTRL) begin
               reg_rdata[EN_BIT] <= engine_en;
               reg_rdata[MED_BIT] <= median_en;
            end else if (reg_addr == ADDR_FILT) begin
               reg_rdata[FILT_LSB +: 12] <= filt_org;
            end else if (reg_addr == ADDR_STATUS) begin
               reg_rdata[ST_BUSY_BIT] <= vstate == AFPG_WAIT ||
                                         vstate == AFPG_ROWS;
               reg_rdata[ST_DONE_BIT] <= frame_done;
               reg_rdata[ST_COL_LSB +: 6] <= col;
               reg_rdata[ST_ROW_LSB +: 7] <= row;
            end
         end
      end
   end

   // position of the pixel now on the input
   always_comb begin
      next_h = pix.sol ? '0 : hcnt + 1'b1;
      next_v = vcnt;
      if (pix.sof) begin
         next_v = '0;
      end else if (pix.sol) begin
         next_v = vcnt + 1'b1;
      end
   end

   // vertical walk, re-evaluated on each line's first pixel
   always_comb begin
      next_vstate = vstate;
      next_ln = ln;
      next_poff = poff;
      next_row = row;
      if (!engine_en) begin
         next_vstate = AFPG_IDLE;
      end else if (pix.sol) begin
         if (pix.sof) begin
            next_vstate = AFPG_WAIT;
         end
         case (pix.sof ? AFPG_WAIT : vstate)
            AFPG_WAIT: begin
               if (next_v == POS_W'(v_org)) begin
                  next_vstate = AFPG_ROWS;
                  next_row = 7'h00;
                  next_ln = 8'h00;
                  next_poff = 5'h00;
               end
            end
            AFPG_ROWS: begin
               if (ln == hlast) begin
                  if (row == rows_f) begin
                     next_vstate = AFPG_DONE;
                  end else begin
                     next_row = row + 7'h01;
                     next_ln = 8'h00;
                     next_poff = 5'h00;
                  end
               end else begin
                  next_ln = ln + 8'h01;
                  // a zero step field wraps every pair: no line skipped
                  next_poff = (poff == slast) ? 5'h00 : poff + 5'h01;
               end
            end
            default: begin
               next_vstate = vstate;
            end
         endcase
      end
   end

   // horizontal walk across the columns of a line
   always_comb begin
      next_h_on = h_on;
      next_h_done = h_done;
      next_col = col;
      next_cpix = cpix;
      if (pix.sol) begin
         next_h_on = 1'b0;
         next_h_done = 1'b0;
         next_col = 6'h00;
         next_cpix = 8'h00;
      end else if (h_on) begin
         if (cpix == wlast) begin
            if (col == cols_f) begin
               next_h_on = 1'b0;
               next_h_done = 1'b1;
            end else begin
               next_col = col + 6'h01;
               next_cpix = 8'h00;
            end
         end else begin
            next_cpix = cpix + 8'h01;
         end
      end
      if (!next_h_on && !next_h_done && next_h == POS_W'(h_org)) begin
         next_h_on = 1'b1;
         next_col = 6'h00;
         next_cpix = 8'h00;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hcnt <= '0;
         vcnt <= '0;
      end else if (go) begin
         hcnt <= next_h;
         vcnt <= next_v;
      end
   end

   // disabling takes effect at once, not only on a pixel
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         vstate <= AFPG_IDLE;
         ln <= 8'h00;
         poff <= 5'h00;
         row <= 7'h00;
      end else if (ce && (pix.valid || !engine_en)) begin
         vstate <= next_vstate;
         ln <= next_ln;
         poff <= next_poff;
         row <= next_row;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         h_on <= 1'b0;
         h_done <= 1'b0;
         col <= 6'h00;
         cpix <= 8'h00;
      end else if (go) begin
         h_on <= next_h_on;
         h_done <= next_h_done;
         col <= next_col;
         cpix <= next_cpix;
      end
   end

   // frame completion stays visible until the next frame starts
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         frame_done <= 1'b0;
      end else if (go) begin
         if (next_vstate == AFPG_DONE && vstate == AFPG_ROWS) begin
            frame_done <= 1'b1;
         end else if (pix.sof) begin
            frame_done <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         grid <= '0;
      end else if (ce) begin
         grid.in_paxel <= go && engine_en && next_h_on &&
                          next_vstate == AFPG_ROWS &&
                          next_poff < 5'h02;
         grid.first <= go && next_h_on && next_cpix == 8'h00;
         grid.col <= next_col;
         grid.row <= next_row;
         // shift registers restart on the pixel after the match
         grid.filter_clear <= go && next_h == POS_W'(filt_org);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   AST_PIX_BOUND: assert property (h_on |-> cpix <= wlast)
      else $error("pixel index passed paxel width");
   AST_LN_BOUND: assert property (
      vstate == AFPG_ROWS |-> ln <= hlast)
      else $error("line index passed paxel height");
   AST_STEP: assert property (
      vstate == AFPG_ROWS |-> poff <= slast)
      else $error("pair offset passed line step");
   AST_FIRST_PAIR: assert property (
      vstate == AFPG_ROWS && ln < 8'h02 |-> poff == ln[4:0])
      else $error("first line pair not processed");
   AST_ROW_BOUND: assert property (row <= rows_f || vstate != AFPG_ROWS)
      else $error("row index passed row count");
   AST_COL_BOUND: assert property (h_on |-> col <= cols_f)
      else $error("column index passed column count");
   AST_ENABLE: assert property (
      ce && !engine_en |=> !grid.in_paxel ##1 vstate == AFPG_IDLE)
      else $error("paxel output while engine disabled");
   AST_FCLR: assert property (
      go && next_h == POS_W'(filt_org) |=> grid.filter_clear)
      else $error("filter clear missed");
   AST_VORG: assert property (
      vstate == AFPG_ROWS && $past(vstate) == AFPG_WAIT
      |-> row == 7'h00 && ln == 8'h00 && vcnt == POS_W'(v_org))
      else $error("first row not at vertical origin");
   AST_HORG: assert property (
      h_on && !$past(h_on) |-> col == 6'h00 && cpix == 8'h00 &&
      hcnt == POS_W'(h_org))
      else $error("first column not at horizontal origin");
   AST_RSV: assert property (
      ce && reg_rd && reg_addr == ADDR_SIZE
      |=> reg_rdata[31:23] == 9'h000 && reg_rdata[15:7] == 9'h000)
      else $error("reserved bits not zero");

   COV_PAXEL: cover property (grid.in_paxel ##1 grid.in_paxel);
   COV_DONE: cover property (vstate == AFPG_ROWS ##1 vstate == AFPG_DONE);
   COV_SKIP: cover property (vstate == AFPG_ROWS && poff > 5'h01);
   COV_FCLR: cover property (grid.filter_clear);

endmodule

// File: tb/afpg_pix_src.sv
`timescale 1ns/100ps
module afpg_pix_src
   import afpg_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic go,
   input wire logic stall,
   input wire logic [11:0] line_px,
   input wire logic [11:0] n_lines,
   output afpg_pix_t pix,
   output logic busy
);
   logic [11:0] h;
   logic [11:0] v;
   logic skip;
   // two idle cycles close each line; flags toggle while not qualified
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
         h <= 12'h000;
         v <= 12'h000;
         skip <= 1'b0;
         pix <= '0;
      end else if (!busy || (stall && !skip)) begin
         skip <= busy;
         pix.valid <= 1'b0;
         pix.sof <= ~pix.sof;
         pix.sol <= ~pix.sol;
         if (!busy && go) begin
            busy <= 1'b1;
            h <= 12'h000;
            v <= 12'h000;
         end
      end else begin
         skip <= 1'b0;
         pix.valid <= h < line_px;
         pix.sol <= (h < line_px) ? h == 12'h000 : ~pix.sol;
         pix.sof <= (h < line_px) ? (h == 12'h000 && v == 12'h000) : ~pix.sof;
         if (h == line_px + 12'h001) begin
            h <= 12'h000;
            v <= v + 12'h001;
            if (v == n_lines - 12'h001) begin
               busy <= 1'b0;
            end
         end else begin
            h <= h + 12'h001;
         end
      end
   end
endmodule

// File: tb/test_afpg_grid.sv
`timescale 1ns/100ps
module test_afpg_grid;
   import afpg_pkg::*;
   logic clock = 0, arst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0;
   logic go = 0, stall = 0, busy;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata, rv;
   logic [11:0] line_px = 12'h010, n_lines = 12'h008;
   afpg_pix_t pix;
   afpg_grid_t grid;
   int n_errors = 0, checks = 0, n_in, n_first, n_clr, col_sum, row_sum;
   always #12.5 clock = ~clock;
   afpg_grid DUT (.clock(clock), .arst_n(arst_n), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix(pix), .grid(grid));
   afpg_pix_src SRC (.clock(clock), .arst_n(arst_n), .go(go),
      .stall(stall), .line_px(line_px), .n_lines(n_lines), .pix(pix),
      .busy(busy));
   always @(posedge clock) begin
      if (grid.filter_clear === 1'b1) n_clr++;
      if (grid.in_paxel === 1'b1) begin
         n_in++;
         n_first += int'(grid.first);
         col_sum += int'(grid.col);
         row_sum += int'(grid.row);
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task cfg(input int w, h, s, r, c, ho, vo, fo, en);
      // engine off first, so no walk in progress sees a half-written setup
      wr(ADDR_CTRL, 32'h00000000);
      wr(ADDR_SIZE, 32'((w << WIDTH_LSB) | (h << HEIGHT_LSB)));
      wr(ADDR_GRID, 32'((s << STEP_LSB) | (r << ROWS_LSB) | (c << COLS_LSB)));
      wr(ADDR_ORIGIN, 32'((ho << HORG_LSB) | (vo << VORG_LSB)));
      wr(ADDR_FILT, 32'(fo << FILT_LSB));
      wr(ADDR_CTRL, 32'(en << EN_BIT));
   endtask
   task frame(input int lines, px);
      @(posedge clock);
      #1 {n_in, n_first, n_clr, col_sum, row_sum} = '0;
      @(posedge clock);
      line_px <= 12'(px);
      n_lines <= 12'(lines);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      @(posedge clock);
      for (int i = 0; i < 4000 && busy === 1'b1; i++) @(posedge clock);
      // a source that never finishes counts as a failure
      if (busy !== 1'b0) n_errors++;
      repeat (3) @(posedge clock);
   endtask
   task t_regs;
      logic [7:0] a[3];
      logic [31:0] m[3];
      a = '{ADDR_SIZE, ADDR_GRID, ADDR_ORIGIN};
      m = '{32'h007f007f, 32'h0001ffff, 32'h0fff0fff};
      for (int i = 0; i < 3; i++) begin
         rd(a[i]);
         chk(rv, 32'h00000000);
         wr(a[i], 32'hffffffff);
         rd(a[i]);
         chk(rv, m[i]);
         @(posedge clock);
         #1 chk(reg_rdata, 32'h00000000);
      end
      wr(8'h40, 32'hffffffff);
      rd(8'h40);
      chk(rv, 32'h00000000);
      // a write while the clock enable is low must be lost
      @(posedge clock);
      ce <= 1'b0;
      wr(ADDR_SIZE, 32'h00000000);
      ce <= 1'b1;
      rd(ADDR_SIZE);
      chk(rv, 32'h007f007f);
      $display("test regs done");
   endtask
   // software limits kept: even origin beyond filter, columns in range
   task t_grid;
      cfg(2, 0, 0, 1, 1, 4, 2, 3, 1);
      stall <= 1'b1;
      frame(5, 20);
      stall <= 1'b0;
      // lines 2..4 processed: two columns of 6 pixels each
      chk(32'(n_in), 32'(3 * 2 * 6));
      chk(32'(n_first), 32'(3 * 2));
      chk(32'(col_sum), 32'(3 * 6));
      chk(32'(row_sum), 32'(1 * 2 * 6));
      chk(32'(n_clr), 32'(5));
      $display("test grid done");
   endtask
   task t_step;
      int ht[4], st[4], e;
      ht = '{3, 3, 15, 7};
      st = '{1, 0, 15, 3};
      for (int k = 0; k < 4; k++) begin
         cfg(2, ht[k], st[k], 0, 0, 2, 0, 0, 1);
         frame(2 * (ht[k] + 1) + 2, 12);
         e = 0;
         for (int l = 0; l < 2 * (ht[k] + 1); l++)
            if (l % (2 * (st[k] + 1)) < 2) e++;
         chk(32'(n_in), 32'(e * 6));
         rd(ADDR_STATUS);
         chk(rv & 32'h00000003, 32'h00000002);
      end
      $display("test step done");
   endtask
   task t_off;
      cfg(2, 0, 0, 0, 0, 2, 0, 0, 0);
      frame(4, 12);
      chk(32'(n_in), 32'(0));
      $display("test off done");
   endtask
   task give_verdict;
      $display("checks=%0d errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      t_regs;
      t_grid;
      t_step;
      t_off;
      give_verdict;
   end
   // the frames above need well under 5000 cycles
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      give_verdict;
   end
endmodule
